// >>> hw/reset_strap_config_select_defines.vh
`ifndef RESET_STRAP_CONFIG_SELECT_DEFINES_VH
`define RESET_STRAP_CONFIG_SELECT_DEFINES_VH

// ****************************************************
// Pin map
// ****************************************************
`define GPIO_COUNT        16
`define GPIO_SERIAL_SEL   9
`define GPIO_MUST_HIGH    8
`define CFG_INDEX_WIDTH   4
`define OUTPUT_COUNT      8

// ****************************************************
// Strap function masks when no info block is present
// ****************************************************
`define DEF_CFG_SEL_MASK  16'h000f
`define DEF_EEPROM_MASK   16'h0000
`define DEF_ADDR_MASK     16'h0000

// ****************************************************
// Setting register addresses
// ****************************************************
`define REG_SERIAL        2'h0
`define REG_EEPROM        2'h1
`define REG_OUT_EN        2'h2
`define REG_GPIO_OE       2'h3

// ****************************************************
// Field positions
// ****************************************************
`define SERIAL_I2C_BIT    0
`define SERIAL_A2_BIT     1
`define EEPROM_DIS_BIT    0

// ****************************************************
// Reset values
// ****************************************************
`define RST_OUT_EN        8'h00
`define RST_GPIO_OE       16'h0000
`define RST_CFG_INDEX     4'h0

`endif

// >>> hw/strap_field_extract.v
`timescale 1ns/10ps

// ****************************************************
// Per-function strap decode
// ****************************************************
module strap_field_extract #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] pins,
  input  wire [WIDTH-1:0] mask,
  output reg              anySel,
  output reg              highestBit,
  output reg              orBit,
  output reg  [WIDTH-1:0] packWord
);

  integer i;
  integer pos;

  always @* begin
    anySel     = 1'b0;
    highestBit = 1'b0;
    orBit      = 1'b0;
    packWord   = {WIDTH{1'b0}};
    pos        = 0;
    for (i = 0; i < WIDTH; i = i + 1) begin
      if (mask[i]) begin
        anySel      = 1'b1;
        highestBit  = pins[i];
        orBit       = orBit | pins[i];
        packWord[pos] = pins[i];
        pos         = pos + 1;
      end
    end
  end

endmodule // strap_field_extract

// >>> hw/reset_strap_config_select.v
`timescale 1ns/10ps
`include "reset_strap_config_select_defines.vh"

// Operation
// - Sample every GPIO on master reset rising edge to seed configuration.
// - Captured GPIO 9: low selects SPI, high selects I2C main port.
// - Address strap pin gives I2C address bit A2, else zero.
// - Several address strap pins: only highest index pin counts.
// - Address strap ignored when main port is SPI.
// - Any high EEPROM-disable strap blocks external EEPROM reads (OR).
// - No EEPROM-disable pin assigned: search for EEPROM at start-up.
// - No selection pins assigned: GPIO 3..0 form configuration index.
// - Undriven default pins pull up, selecting configuration 15.
// - Selection pins packed by index, lowest pin is LSB.
// - Fewer than four pins: upper index bits are zero.
// - More than four pins form a wider selection word.
// - Selection straps captured even when no configuration sets are stored.
// - Info block assigns strap pins; unprogrammed parts use defaults.
// - Info block may pick any number of arbitrary selection pins, up to all 16.
// - Strap-derived settings live in registers later writes may change.
// - Without loaded data, outputs disabled and GPIOs all inputs.
// - Reset brings up regulators, clocks, PLL calibration and lock.
// - Stored configuration with bad checksum is not applied.
module reset_strap_config_select (
  input  wire                          core_clk,
  input  wire                          srst,
  input  wire                          clkEn,
  input  wire                          masterResetInN,
  input  wire [`GPIO_COUNT-1:0]        gpioIn,
  input  wire                          infoBlockValid,
  input  wire [`GPIO_COUNT-1:0]        infoCfgSelMask,
  input  wire [`GPIO_COUNT-1:0]        infoEepromDisMask,
  input  wire [`GPIO_COUNT-1:0]        infoAddrMask,
  input  wire                          configSetsPresent,
  input  wire                          regulatorsReady,
  input  wire                          clocksReady,
  input  wire                          pllCalDone,
  input  wire                          pllLocked,
  input  wire                          loadDone,
  input  wire                          loadChecksumOk,
  input  wire                          loadWrEn,
  input  wire [1:0]                    loadWrAddr,
  input  wire [`GPIO_COUNT-1:0]        loadWrData,
  input  wire                          eepromDone,
  input  wire                          hostWrEn,
  input  wire [1:0]                    hostWrAddr,
  input  wire [`GPIO_COUNT-1:0]        hostWrData,
  output wire                          inReset,
  output reg                           regulatorEn_q,
  output reg                           clocksEn_q,
  output reg                           pllCalStart_q,
  output reg                           cfgLoadReq_q,
  output reg                           eepromSearchReq_q,
  output reg                           startupDone_q,
  output reg  [`GPIO_COUNT-1:0]        strapCapture_q,
  output reg  [`CFG_INDEX_WIDTH-1:0]   cfgIndex_q,
  output reg  [`GPIO_COUNT-1:0]        cfgSelWord_q,
  output reg                           serialI2c_q,
  output reg                           i2cAddrA2_q,
  output reg                           eepromDisable_q,
  output reg  [`OUTPUT_COUNT-1:0]      outputEnable_q,
  output reg  [`GPIO_COUNT-1:0]        gpioOutEnable_q,
  output reg                           strapFault_q
);

  // ****************************************************
  // Start-up sequence states
  // ****************************************************
  localparam ST_HOLD   = 3'h0;
  localparam ST_REG    = 3'h1;
  localparam ST_CLK    = 3'h2;
  localparam ST_PLLCAL = 3'h3;
  localparam ST_LOCK   = 3'h4;
  localparam ST_LOAD   = 3'h5;
  localparam ST_EEPROM = 3'h6;
  localparam ST_RUN    = 3'h7;

  reg  [2:0]                 state_q;
  reg  [2:0]                 state_d;
  reg                        mrPrev_q;
  reg  [`OUTPUT_COUNT-1:0]   stageOutEn_q;
  reg  [`GPIO_COUNT-1:0]     stageGpioOe_q;
  reg                        stageSerial_q;
  reg                        stageA2_q;
  reg                        stageEeprom_q;
  reg                        stageSerialHit_q;
  reg                        stageEepromHit_q;

  wire                       mrRise;
  wire [`GPIO_COUNT-1:0]     cfgMask;
  wire [`GPIO_COUNT-1:0]     eepromMask;
  wire [`GPIO_COUNT-1:0]     addrMask;
  wire                       addrAny;
  wire                       addrBit;
  wire                       eepromAny;
  wire                       eepromOr;
  wire [`GPIO_COUNT-1:0]     cfgPacked;
  wire                       strapI2c;
  wire                       loadCommit;

  assign inReset = ~masterResetInN;
  assign mrRise  = masterResetInN & ~mrPrev_q;

  // ****************************************************
  // Strap function assignment
  // ****************************************************
  assign cfgMask    = infoBlockValid ? infoCfgSelMask : `DEF_CFG_SEL_MASK;
  assign eepromMask = infoBlockValid ? infoEepromDisMask : `DEF_EEPROM_MASK;
  assign addrMask   = infoBlockValid ? infoAddrMask : `DEF_ADDR_MASK;
  assign strapI2c   = gpioIn[`GPIO_SERIAL_SEL];

  strap_field_extract #(
    .WIDTH      (`GPIO_COUNT)
  ) uCfgSel (
    .pins       (gpioIn),
    .mask       (cfgMask | ((|cfgMask) ? {`GPIO_COUNT{1'b0}} : `DEF_CFG_SEL_MASK)),
    .anySel     (),
    .highestBit (),
    .orBit      (),
    .packWord   (cfgPacked)
  );

  strap_field_extract #(
    .WIDTH      (`GPIO_COUNT)
  ) uEepromDis (
    .pins       (gpioIn),
    .mask       (eepromMask),
    .anySel     (eepromAny),
    .highestBit (),
    .orBit      (eepromOr),
    .packWord   ()
  );

  strap_field_extract #(
    .WIDTH      (`GPIO_COUNT)
  ) uAddrA2 (
    .pins       (gpioIn),
    .mask       (addrMask),
    .anySel     (addrAny),
    .highestBit (addrBit),
    .orBit      (),
    .packWord   ()
  );

  // ****************************************************
  // Sequence next state
  // ****************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:   if (mrRise) state_d = ST_REG;
      ST_REG:    if (regulatorsReady) state_d = ST_CLK;
      ST_CLK:    if (clocksReady) state_d = ST_PLLCAL;
      ST_PLLCAL: if (pllCalDone) state_d = ST_LOCK;
      ST_LOCK: begin
        if (pllLocked) begin
          if (configSetsPresent) begin
            state_d = ST_LOAD;
          end else if (!eepromDisable_q) begin
            state_d = ST_EEPROM;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_LOAD: begin
        if (loadDone) begin
          state_d = eepromDisable_q ? ST_RUN : ST_EEPROM;
        end
      end
      ST_EEPROM: if (eepromDone) state_d = ST_RUN;
      ST_RUN:    state_d = ST_RUN;
      default:   state_d = ST_HOLD;
    endcase
  end

  assign loadCommit = (state_q == ST_LOAD) & loadDone & loadChecksumOk;

  // ****************************************************
  // Sequencer and request outputs
  // ****************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      state_q           <= ST_HOLD;
      mrPrev_q          <= 1'b0;
      regulatorEn_q     <= 1'b0;
      clocksEn_q        <= 1'b0;
      pllCalStart_q     <= 1'b0;
      cfgLoadReq_q      <= 1'b0;
      eepromSearchReq_q <= 1'b0;
      startupDone_q     <= 1'b0;
    end else if (clkEn) begin
      mrPrev_q <= masterResetInN;
      if (!masterResetInN) begin
        state_q           <= ST_HOLD;
        regulatorEn_q     <= 1'b0;
        clocksEn_q        <= 1'b0;
        pllCalStart_q     <= 1'b0;
        cfgLoadReq_q      <= 1'b0;
        eepromSearchReq_q <= 1'b0;
        startupDone_q     <= 1'b0;
      end else begin
        state_q           <= state_d;
        regulatorEn_q     <= regulatorEn_q | (state_d == ST_REG);
        clocksEn_q        <= clocksEn_q | (state_d == ST_CLK);
        pllCalStart_q     <= (state_d == ST_PLLCAL) & (state_q != ST_PLLCAL);
        cfgLoadReq_q      <= (state_d == ST_LOAD) & (state_q != ST_LOAD);
        eepromSearchReq_q <= (state_d == ST_EEPROM) & (state_q != ST_EEPROM);
        startupDone_q     <= (state_d == ST_RUN);
      end
    end
  end

  // ****************************************************
  // Strap capture, held until next reset release
  // ****************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      strapCapture_q <= {`GPIO_COUNT{1'b0}};
      cfgSelWord_q   <= {`GPIO_COUNT{1'b0}};
      cfgIndex_q     <= `RST_CFG_INDEX;
      strapFault_q   <= 1'b0;
    end else if (clkEn) begin
      if (!masterResetInN && !gpioIn[`GPIO_MUST_HIGH]) begin
        strapFault_q <= 1'b1;
      end else if (mrRise) begin
        strapFault_q <= strapFault_q & ~gpioIn[`GPIO_MUST_HIGH];
      end
      if (mrRise) begin
        strapCapture_q <= gpioIn;
        cfgSelWord_q   <= cfgPacked;
        cfgIndex_q     <= cfgPacked[`CFG_INDEX_WIDTH-1:0];
      end
    end
  end

  // ****************************************************
  // Staging of stored configuration writes
  // ****************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      stageOutEn_q     <= `RST_OUT_EN;
      stageGpioOe_q    <= `RST_GPIO_OE;
      stageSerial_q    <= 1'b0;
      stageA2_q        <= 1'b0;
      stageEeprom_q    <= 1'b0;
      stageSerialHit_q <= 1'b0;
      stageEepromHit_q <= 1'b0;
    end else if (clkEn) begin
      if (cfgLoadReq_q) begin
        stageOutEn_q     <= `RST_OUT_EN;
        stageGpioOe_q    <= `RST_GPIO_OE;
        stageSerialHit_q <= 1'b0;
        stageEepromHit_q <= 1'b0;
      end else if (loadWrEn && state_q == ST_LOAD) begin
        case (loadWrAddr)
          `REG_SERIAL: begin
            stageSerial_q    <= loadWrData[`SERIAL_I2C_BIT];
            stageA2_q        <= loadWrData[`SERIAL_A2_BIT];
            stageSerialHit_q <= 1'b1;
          end
          `REG_EEPROM: begin
            stageEeprom_q    <= loadWrData[`EEPROM_DIS_BIT];
            stageEepromHit_q <= 1'b1;
          end
          `REG_OUT_EN:  stageOutEn_q  <= loadWrData[`OUTPUT_COUNT-1:0];
          `REG_GPIO_OE: stageGpioOe_q <= loadWrData;
          default:      stageGpioOe_q <= stageGpioOe_q;
        endcase
      end
    end
  end

  // ****************************************************
  // Settings registers
  // ****************************************************
  always @(posedge core_clk) begin
    if (srst) begin
      serialI2c_q     <= 1'b0;
      i2cAddrA2_q     <= 1'b0;
      eepromDisable_q <= 1'b0;
      outputEnable_q  <= `RST_OUT_EN;
      gpioOutEnable_q <= `RST_GPIO_OE;
    end else if (clkEn) begin
      if (!masterResetInN) begin
        outputEnable_q  <= `RST_OUT_EN;
        gpioOutEnable_q <= `RST_GPIO_OE;
      end else if (mrRise) begin
        serialI2c_q     <= strapI2c;
        i2cAddrA2_q     <= strapI2c & addrAny & addrBit;
        eepromDisable_q <= eepromAny & eepromOr;
      end else if (hostWrEn && startupDone_q) begin
        case (hostWrAddr)
          `REG_SERIAL: begin
            serialI2c_q <= hostWrData[`SERIAL_I2C_BIT];
            i2cAddrA2_q <= hostWrData[`SERIAL_A2_BIT];
          end
          `REG_EEPROM:  eepromDisable_q <= hostWrData[`EEPROM_DIS_BIT];
          `REG_OUT_EN:  outputEnable_q  <= hostWrData[`OUTPUT_COUNT-1:0];
          `REG_GPIO_OE: gpioOutEnable_q <= hostWrData;
          default:      gpioOutEnable_q <= gpioOutEnable_q;
        endcase
      end else if (loadCommit) begin
        if (stageSerialHit_q) begin
          serialI2c_q <= stageSerial_q;
          i2cAddrA2_q <= stageA2_q;
        end
        if (stageEepromHit_q) begin
          eepromDisable_q <= stageEeprom_q;
        end
        outputEnable_q  <= stageOutEn_q;
        gpioOutEnable_q <= stageGpioOe_q;
      end
    end
  end

endmodule // reset_strap_config_select

// >>> dv/board_strap_model.sv
`timescale 1ns/10ps

// ****************************************************
// Board straps and reset driver
// ****************************************************
module board_strap_model (
  input  wire        core_clk,
  input  wire        mrReq,
  input  wire        breakHold,
  input  wire [15:0] drvVal,
  input  wire [15:0] drvEn,
  output reg         masterResetInN = 1'b0,
  output wire [15:0] gpioIn
);
  // Undriven pins float up to the pull-up level
  wire [15:0] level = (drvVal & drvEn) | ~drvEn;

  // No test access pins are among the straps driven here
  always @(posedge core_clk) begin
    masterResetInN <= ~mrReq;
  end

  // Pin 8 held high in reset unless told to misbehave
  assign gpioIn = {level[15:9], level[8] | (~masterResetInN & ~breakHold), level[7:0]};
endmodule // board_strap_model

// >>> dv/reset_strap_config_select_assertions.sv
`timescale 1ns/10ps
`include "reset_strap_config_select_defines.vh"

// ****************************************************
// Strap capture checks
// ****************************************************
module strap_checker (
  input wire                        core_clk,
  input wire                        srst,
  input wire                        clkEn,
  input wire                        masterResetInN,
  input wire [`GPIO_COUNT-1:0]      gpioIn,
  input wire                        infoBlockValid,
  input wire [`GPIO_COUNT-1:0]      infoCfgSelMask,
  input wire [`GPIO_COUNT-1:0]      infoEepromDisMask,
  input wire                        configSetsPresent,
  input wire                        regulatorEn_q,
  input wire [`GPIO_COUNT-1:0]      strapCapture_q,
  input wire [`CFG_INDEX_WIDTH-1:0] cfgIndex_q,
  input wire                        serialI2c_q,
  input wire                        i2cAddrA2_q,
  input wire                        eepromDisable_q,
  input wire [`OUTPUT_COUNT-1:0]    outputEnable_q,
  input wire [`GPIO_COUNT-1:0]      gpioOutEnable_q,
  input wire                        strapFault_q
);
  reg        mrPrev_q;
  wire       rise = clkEn & masterResetInN & ~mrPrev_q;
  wire       dflt = ~infoBlockValid | ~|infoCfgSelMask;
  wire       eeNow = infoBlockValid & |(gpioIn & infoEepromDisMask);
  wire       serPin = gpioIn[`GPIO_SERIAL_SEL];
  wire [3:0] lowPins = gpioIn[3:0];

  always @(posedge core_clk) begin
    if (srst) mrPrev_q <= 1'b0;
    else if (clkEn) mrPrev_q <= masterResetInN;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  a_capture_all: assert property (rise |=> strapCapture_q == $past(gpioIn))
    else $error("capture differs from pins");
  a_serial_sel: assert property (rise |=> serialI2c_q == $past(serPin))
    else $error("serial select wrong");
  a_addr_spi: assert property (rise && !serPin |=> !i2cAddrA2_q)
    else $error("A2 set with SPI");
  a_eeprom_or: assert property (rise |=> eepromDisable_q == $past(eeNow))
    else $error("eeprom disable wrong");
  a_index_dflt: assert property (rise && dflt && configSetsPresent |=> cfgIndex_q == $past(lowPins))
    else $error("default index wrong");
  a_outputs_off: assert property (rise |=> (outputEnable_q == 8'h00 && gpioOutEnable_q == 16'h0000)[*3])
    else $error("outputs enabled early");
  a_regs_start: assert property (rise |=> regulatorEn_q)
    else $error("regulators not started");
  a_strap_hold: assert property (clkEn && masterResetInN && mrPrev_q |=> $stable(strapCapture_q))
    else $error("capture moved");
  a_pin8_fault: assert property (clkEn && !masterResetInN && !gpioIn[8] |=> strapFault_q)
    else $error("pin 8 fault missed");
endmodule // strap_checker

// >>> dv/reset_strap_config_select_tb.sv
`timescale 1ns/10ps

`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module reset_strap_config_select_tb;
  logic core_clk = 1'b0, srst = 1'b1, clkEn = 1'b1, mrReq = 1'b0, breakHold = 1'b0;
  logic infoBlockValid = 1'b0, configSetsPresent = 1'b0, loadDone = 1'b0, loadChecksumOk = 1'b0;
  logic regulatorsReady = 1'b0, clocksReady = 1'b0, pllCalDone = 1'b0, pllLocked = 1'b0;
  logic loadWrEn = 1'b0, eepromDone = 1'b0, hostWrEn = 1'b0;
  logic [1:0]  loadWrAddr = 2'h0, hostWrAddr = 2'h0;
  logic [15:0] loadWrData = 16'h0, hostWrData = 16'h0, drvVal = 16'h0, drvEn = 16'h0;
  logic [15:0] infoCfgSelMask = 16'h0, infoEepromDisMask = 16'h0, infoAddrMask = 16'h0;
  wire         masterResetInN, regulatorEn_q, pllCalStart_q, cfgLoadReq_q, eepromSearchReq_q;
  wire         startupDone_q, serialI2c_q, i2cAddrA2_q, eepromDisable_q, strapFault_q;
  wire         inReset, clocksEn_q;
  wire [15:0]  gpioIn, strapCapture_q, cfgSelWord_q, gpioOutEnable_q;
  wire [3:0]   cfgIndex_q;
  wire [7:0]   outputEnable_q;
  int          miscompares = 0, numChecks = 0, nLoad = 0, nEe = 0, nCal = 0;

  board_strap_model board (.core_clk, .mrReq, .breakHold, .drvVal, .drvEn, .masterResetInN, .gpioIn);

  reset_strap_config_select uut (
    .core_clk, .srst, .clkEn, .masterResetInN, .gpioIn, .infoBlockValid, .infoCfgSelMask,
    .infoEepromDisMask, .infoAddrMask, .configSetsPresent, .regulatorsReady, .clocksReady,
    .pllCalDone, .pllLocked, .loadDone, .loadChecksumOk, .loadWrEn, .loadWrAddr, .loadWrData,
    .eepromDone, .hostWrEn, .hostWrAddr, .hostWrData, .inReset, .regulatorEn_q,
    .clocksEn_q, .pllCalStart_q, .cfgLoadReq_q, .eepromSearchReq_q, .startupDone_q,
    .strapCapture_q, .cfgIndex_q, .cfgSelWord_q, .serialI2c_q, .i2cAddrA2_q, .eepromDisable_q,
    .outputEnable_q, .gpioOutEnable_q, .strapFault_q);

  initial forever #5 core_clk = ~core_clk;

  // Request pulse counters
  always @(posedge core_clk) begin
    if (cfgLoadReq_q === 1'b1) nLoad++;
    if (eepromSearchReq_q === 1'b1) nEe++;
    if (pllCalStart_q === 1'b1) nCal++;
  end

  task automatic testDone;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Master reset pulse with given straps and info masks
  task automatic strap(input logic [15:0] v, e, cm, em, am, input logic iv);
    @(posedge core_clk);
    {regulatorsReady, clocksReady, pllCalDone, pllLocked, eepromDone} <= 5'h00;
    drvVal <= v;
    drvEn <= e;
    infoCfgSelMask <= cm;
    infoEepromDisMask <= em;
    infoAddrMask <= am;
    infoBlockValid <= iv;
    mrReq <= 1'b1;
    repeat (3) @(posedge core_clk);
    `CHK(inReset, 1'b1)
    mrReq <= 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic t_default;
    strap(16'h0000, 16'h0000, 16'h0, 16'h0, 16'h0, 1'b0);
    `CHK(cfgIndex_q, 4'hf)
    `CHK(serialI2c_q, 1'b1)
    `CHK(i2cAddrA2_q, 1'b0)
    `CHK(eepromDisable_q, 1'b0)
    strap(16'h0005, 16'h020f, 16'h0, 16'h0, 16'h0, 1'b0);
    `CHK(cfgIndex_q, 4'h5)
    `CHK(serialI2c_q, 1'b0)
    `CHK(strapCapture_q, 16'hfdf5)
    strap(16'h0000, 16'h0000, 16'h0030, 16'h1000, 16'h0080, 1'b0);
    `CHK(cfgIndex_q, 4'hf)
    `CHK(eepromDisable_q, 1'b0)
    `CHK(i2cAddrA2_q, 1'b0)
    $display("t_default done");
  endtask

  task automatic t_info;
    strap(16'h0124, 16'h0164, 16'h0164, 16'h0, 16'h0, 1'b1);
    `CHK(cfgIndex_q, 4'hb)
    strap(16'h0400, 16'h0410, 16'h0410, 16'h0, 16'h0, 1'b1);
    `CHK(cfgIndex_q, 4'h2)
    `CHK(cfgSelWord_q, 16'h0002)
    strap(16'h2088, 16'h288a, 16'h288a, 16'h0, 16'h0, 1'b1);
    `CHK(cfgSelWord_q, 16'h0016)
    `CHK(cfgIndex_q, 4'h6)
    $display("t_info done");
  endtask

  task automatic t_addr;
    logic [2:0] i;
    for (int k = 0; k < 8; k++) begin
      i = k[2:0];
      strap({3'b0, i[1], i[0], 1'b0, i[2], 1'b0, i[1], 1'b0, i[0], 5'b0},
            16'h1aa0, 16'h0, 16'h1800, 16'h00a0, 1'b1);
      `CHK(i2cAddrA2_q, i[2] & i[1])
      `CHK(eepromDisable_q, i[1] | i[0])
    end
    $display("t_addr done");
  endtask

  task automatic t_fault;
    strap(16'h0000, 16'h0100, 16'h0, 16'h0, 16'h0, 1'b0);
    `CHK(strapFault_q, 1'b0)
    @(posedge core_clk) breakHold <= 1'b1;
    strap(16'h0000, 16'h0100, 16'h0, 16'h0, 16'h0, 1'b0);
    `CHK(strapFault_q, 1'b1)
    @(posedge core_clk) breakHold <= 1'b0;
    $display("t_fault done");
  endtask

  // Reset pulse while clock enable is low must not disturb anything
  task automatic t_freeze;
    @(posedge core_clk) clkEn <= 1'b0;
    strap(16'h0000, 16'hffff, 16'h0, 16'h0, 16'h0, 1'b0);
    `CHK(strapCapture_q, 16'hfeff)
    @(posedge core_clk) clkEn <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(strapCapture_q, 16'hfeff)
    `CHK(strapFault_q, 1'b1)
    $display("t_freeze done");
  endtask

  // Full bring-up with given sets present (p), checksum good (k), eeprom-disable strap (d) and expected enables
  task automatic boot(input logic p, k, d, input logic [7:0] oe);
    int n;
    @(posedge core_clk) configSetsPresent <= p;
    strap({3'b0, d, 12'h0}, 16'h1000, 16'h0, 16'h1000, 16'h0, 1'b1);
    nLoad = 0;
    nEe = 0;
    nCal = 0;
    @(posedge core_clk) {regulatorsReady, clocksReady, pllCalDone, pllLocked, eepromDone} <= 5'h1f;
    for (n = 0; n < 40 && cfgLoadReq_q !== 1'b1 && startupDone_q !== 1'b1; n++) @(negedge core_clk);
    if (p) begin
      @(posedge core_clk);
      loadWrEn <= 1'b1;
      loadWrAddr <= 2'h2;
      loadWrData <= 16'h00c3;
      @(posedge core_clk);
      loadWrAddr <= 2'h0;
      loadWrData <= 16'h0002;
      @(posedge core_clk);
      loadWrAddr <= 2'h1;
      loadWrData <= 16'h0001;
      @(posedge core_clk);
      loadWrEn <= 1'b0;
      loadDone <= 1'b1;
      loadChecksumOk <= k;
      @(posedge core_clk) loadDone <= 1'b0;
    end
    for (n = 0; n < 40 && startupDone_q !== 1'b1; n++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    `CHK(startupDone_q, 1'b1)
    `CHK(nCal, 1)
    `CHK(outputEnable_q, oe)
    `CHK(gpioOutEnable_q, 16'h0000)
    `CHK(nLoad, p ? 1 : 0)
    `CHK(nEe, d ? 0 : 1)
    `CHK(serialI2c_q, ~(p & k))
    `CHK(i2cAddrA2_q, p & k)
    `CHK(eepromDisable_q, (p & k) | d)
    `CHK(clocksEn_q, 1'b1)
    `CHK(inReset, 1'b0)
    @(posedge core_clk);
    hostWrEn <= 1'b1;
    hostWrAddr <= 2'h3;
    hostWrData <= 16'h5a5a;
    @(posedge core_clk);
    hostWrAddr <= 2'h2;
    hostWrData <= 16'h00a5;
    @(posedge core_clk);
    hostWrAddr <= 2'h0;
    hostWrData <= 16'h0001;
    @(posedge core_clk) hostWrEn <= 1'b0;
    @(negedge core_clk);
    `CHK(gpioOutEnable_q, 16'h5a5a)
    `CHK(outputEnable_q, 8'ha5)
    `CHK(serialI2c_q, 1'b1)
    `CHK(i2cAddrA2_q, 1'b0)
    $display("boot done");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    t_default;
    t_info;
    t_addr;
    t_fault;
    t_freeze;
    boot(1'b1, 1'b0, 1'b1, 8'h00);
    boot(1'b1, 1'b1, 1'b0, 8'hc3);
    boot(1'b0, 1'b1, 1'b0, 8'h00);
    testDone;
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    testDone;
  end
endmodule // reset_strap_config_select_tb

bind reset_strap_config_select strap_checker u_chk (
  .core_clk, .srst, .clkEn, .masterResetInN, .gpioIn, .infoBlockValid, .infoCfgSelMask,
  .infoEepromDisMask, .configSetsPresent, .regulatorEn_q, .strapCapture_q, .cfgIndex_q,
  .serialI2c_q, .i2cAddrA2_q, .eepromDisable_q, .outputEnable_q, .gpioOutEnable_q,
  .strapFault_q);
